// ---- regulator_fault_supervisor_tb_top.sv ----
`timescale 1ns/1ps
module regulator_fault_supervisor_tb_top;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  rfs_pkg::rfs_cmp_t cmp = '0;
  logic              ss = 1'b0, fb_lo = 1'b0, fb_hi = 1'b0, pin_hi, pin_lo;
  logic [1:0]        mode = 2'h0;
  logic              fault_latch, converter_en, ss_discharge, en_sink, en_pullup;
  logic              lowside_force, power_good_out, power_good_oe_n;
  int                error_cnt = 0, check_count = 0, cycles = 0;
  rfs_pkg::rfs_lvl_t lvl;
  assign lvl = '{ss, pin_hi, pin_lo, fb_lo, fb_hi};
  initial forever #5 sys_clk = ~sys_clk;
  rfs_supervisor u_dut (.sys_clk(sys_clk), .rst(rst), .cmp(cmp), .lvl(lvl),
    .fault_latch(fault_latch), .converter_en(converter_en), .ss_discharge(ss_discharge),
    .en_sink(en_sink), .en_pullup(en_pullup), .lowside_force(lowside_force),
    .power_good_out(power_good_out), .power_good_oe_n(power_good_oe_n));
  rfs_pin_model u_pin (.sys_clk(sys_clk), .mode(mode), .en_sink(en_sink),
    .en_pullup(en_pullup), .en_above_hi(pin_hi), .en_below_lo(pin_lo));
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %b, expected %b", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_on(input int lim);
    for (int i = 0; i < lim && converter_en !== 1'b1; i++) cyc(1);
  endtask
  // reset with every input quiet, then wait for soft-start
  task automatic power_up(input logic [1:0] m);
    rst = 1'b1;
    mode = m;
    cmp = '{cool: 1'b1, default: 1'b0};
    {ss, fb_lo, fb_hi} = 3'h0;
    cyc(2);
    chk(fault_latch, 1'b0);
    chk(en_pullup, 1'b1);
    chk(ss_discharge, 1'b1);
    chk(power_good_oe_n, 1'b0);
    chk(converter_en, 1'b0);
    chk(en_sink, 1'b0);
    chk(lowside_force, 1'b0);
    rst = 1'b0;
    wait_on(30);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_uv_pg;
    power_up(2'h0);
    cmp.pg_window = 1'b1;
    cmp.uv = 1'b1;
    cyc(20);
    chk(fault_latch, 1'b0);
    chk(power_good_oe_n, 1'b0);
    cmp.uv = 1'b0;
    ss = 1'b1;
    cyc(3);
    chk(power_good_oe_n, 1'b1);
    chk(power_good_out, 1'b0);
    cmp.pg_window = 1'b0;
    cyc(2);
    chk(power_good_oe_n, 1'b0);
    cmp.ov = 1'b1;
    cyc(1);
    cmp.ov = 1'b0;
    cyc(1);
    chk(fault_latch, 1'b0);
    cmp.uv = 1'b1;
    cyc(15);
    cmp.uv = 1'b0;
    cyc(1);
    cmp.uv = 1'b1;
    cyc(15);
    chk(fault_latch, 1'b0);
    cyc(1);
    chk(fault_latch, 1'b1);
    chk(converter_en, 1'b0);
    chk(ss_discharge, 1'b1);
    chk(en_sink, 1'b1);
    chk(en_pullup, 1'b0);
    cmp.uv = 1'b0;
    wait_on(40);
    chk(converter_en, 1'b1);
    chk(fault_latch, 1'b0);
    chk(ss_discharge, 1'b0);
  endtask
  task automatic t_fast_trips;
    power_up(2'h0);
    cmp.ov = 1'b1;
    cyc(1);
    chk(fault_latch, 1'b0);
    cyc(1);
    chk(fault_latch, 1'b1);
    power_up(2'h0);
    cmp.sw_high = 1'b1;
    cyc(3);
    chk(fault_latch, 1'b0);
    cmp.lowside_on = 1'b1;
    cyc(1);
    chk(fault_latch, 1'b1);
    power_up(2'h0);
    cmp.ilim = 1'b1;
    fb_lo = 1'b1;
    cyc(15);
    chk(fault_latch, 1'b0);
    cyc(1);
    chk(fault_latch, 1'b1);
    chk(lowside_force, 1'b0);
  endtask
  task automatic t_hot;
    power_up(2'h0);
    cmp.cool = 1'b0;
    cmp.hot = 1'b1;
    cyc(1);
    chk(fault_latch, 1'b1);
    cmp.hot = 1'b0;
    cyc(40);
    chk(converter_en, 1'b0);
    cmp.cool = 1'b1;
    wait_on(10);
    chk(converter_en, 1'b1);
  endtask
  task automatic t_cap;
    power_up(2'h3);
    cmp.ov = 1'b1;
    cyc(2);
    cmp.ov = 1'b0;
    wait_on(60);
    chk(converter_en, 1'b0);
    wait_on(300);
    chk(converter_en, 1'b1);
  endtask
  task automatic t_tied_high;
    power_up(2'h1);
    fb_hi = 1'b1;
    cmp.ov = 1'b1;
    cyc(2);
    cmp.ov = 1'b0;
    chk(lowside_force, 1'b1);
    {fb_lo, fb_hi} = 2'h2;
    cyc(2);
    chk(lowside_force, 1'b0);
    fb_lo = 1'b0;
    cyc(3);
    chk(lowside_force, 1'b0);
    fb_hi = 1'b1;
    cyc(2);
    chk(lowside_force, 1'b1);
    cyc(100);
    chk(converter_en, 1'b0);
    chk(fault_latch, 1'b1);
    power_up(2'h2);
    chk(converter_en, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    t_uv_pg();
    t_fast_trips();
    t_hot();
    t_cap();
    t_tied_high();
    summarize();
  end
endmodule // regulator_fault_supervisor_tb_top

// ---- rfs_params.svh ----
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH
`define RFS_UV_COUNT     5'h10
`define RFS_OV_COUNT     5'h02
`define RFS_ILIM_COUNT   5'h10
`define RFS_CNT_RESET    5'h00
`endif

// ---- rfs_pin_model.sv ----
`timescale 1ns/1ps
module rfs_pin_model (
  input  wire logic       sys_clk,     // oscillator clock
  input  wire logic [1:0] mode,        // 0 open, 1 tied high, 2 grounded, 3 capacitor
  input  wire logic       en_sink,     // sink from the block
  input  wire logic       en_pullup,   // pull-up from the block
  output logic            en_above_hi, // pin above 1.35V
  output logic            en_below_lo  // pin below 1.1V
);
  // pin level in 10 mV steps; a capacitor slows both slopes
  int pin_lvl = 0;
  int step;
  always @(posedge sys_clk) begin
    step = (mode == 2'h3) ? 2 : 50;
    if (mode == 2'h1) pin_lvl <= 500;
    else if (mode == 2'h2) pin_lvl <= 0;
    else if (en_sink) pin_lvl <= (pin_lvl > step) ? pin_lvl - step : 0;
    else if (en_pullup) pin_lvl <= (pin_lvl + step < 500) ? pin_lvl + step : 500;
  end
  assign en_above_hi = pin_lvl > 135;
  assign en_below_lo = pin_lvl < 110;
endmodule // rfs_pin_model

// ---- rfs_pkg.sv ----
package rfs_pkg;
  typedef enum logic [2:0] {
    RFS_OFF, RFS_SOFT_START, RFS_RUN, RFS_DISCHARGE, RFS_RECHARGE
  } rfs_state_t;
  typedef struct packed {
    logic uv;        // feedback under the under-voltage threshold
    logic ov;        // feedback over the over-voltage threshold
    logic sw_high;   // switch node above the short threshold
    logic lowside_on; // low-side transistor fully on
    logic ilim;      // cycle ended by the current limit
    logic hot;       // die at the shutdown temperature
    logic cool;      // die below the restart temperature
    logic pg_window; // feedback inside the power-good window
  } rfs_cmp_t;
  typedef struct packed {
    logic ss_at_1v0;  // ramp reached the latch enable point
    logic en_above_hi; // turn-on pin above 1.35V
    logic en_below_lo; // turn-on pin below 1.1V
    logic fb_below_lo; // feedback below 0.25V
    logic fb_above_hi; // feedback above 0.5V
  } rfs_lvl_t;
endpackage

// ---- rfs_supervisor.sv ----
`timescale 1ns/1ps
`include "rfs_params.svh"
module rfs_supervisor (
  input  wire logic            sys_clk,          // switching oscillator clock
  input  wire logic            rst,              // lockout or turn-on toggle, sync high
  input  wire rfs_pkg::rfs_cmp_t cmp,            // fault comparators, one sample per cycle
  input  wire rfs_pkg::rfs_lvl_t lvl,            // ramp, pin and feedback levels
  output logic                 fault_latch,      // shared fault latch
  output logic                 converter_en,     // switching allowed
  output logic                 ss_discharge,     // hold soft-start ramp discharged
  output logic                 en_sink,          // turn-on pin current sink active
  output logic                 en_pullup,        // turn-on pin pull-up active
  output logic                 lowside_force,    // low-side on for output discharge
  output logic                 power_good_out,   // open-drain data, always 0
  output logic                 power_good_oe_n   // low while pulling power-good low
);
  rfs_pkg::rfs_state_t state_reg, state_next;
  logic [4:0] uv_cnt_reg, uv_cnt_next;
  logic [4:0] ov_cnt_reg, ov_cnt_next;
  logic [4:0] il_cnt_reg, il_cnt_next;
  logic       latch_en_reg;
  logic       dis_reg;
  logic       hold_hot_reg;

  //////////////////////////////////////////////////////////////////////////////
  wire        active   = (state_reg == rfs_pkg::RFS_SOFT_START) ||
                         (state_reg == rfs_pkg::RFS_RUN);
  wire        uv_armed = active && lvl.ss_at_1v0;
  assign uv_cnt_next = (uv_armed && cmp.uv) ?
                       ((uv_cnt_reg == `RFS_UV_COUNT) ? uv_cnt_reg : uv_cnt_reg + 5'h01) :
                       `RFS_CNT_RESET;
  assign ov_cnt_next = (active && cmp.ov) ?
                       ((ov_cnt_reg == `RFS_OV_COUNT) ? ov_cnt_reg : ov_cnt_reg + 5'h01) :
                       `RFS_CNT_RESET;
  assign il_cnt_next = (active && cmp.ilim) ?
                       ((il_cnt_reg == `RFS_ILIM_COUNT) ? il_cnt_reg : il_cnt_reg + 5'h01) :
                       `RFS_CNT_RESET;
  wire        uv_trip  = uv_cnt_next == `RFS_UV_COUNT;
  wire        ov_trip  = ov_cnt_next == `RFS_OV_COUNT;
  wire        il_trip  = il_cnt_next == `RFS_ILIM_COUNT;
  wire        hs_short = active && cmp.sw_high && cmp.lowside_on;
  wire        ot_trip  = active && cmp.hot;
  wire        trip     = uv_trip || ov_trip || il_trip || hs_short || ot_trip;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rfs_pkg::RFS_OFF:
        if (lvl.en_above_hi) begin
          state_next = rfs_pkg::RFS_SOFT_START;
        end
      rfs_pkg::RFS_SOFT_START:
        if (trip) begin
          state_next = rfs_pkg::RFS_DISCHARGE;
        end else if (lvl.ss_at_1v0) begin
          state_next = rfs_pkg::RFS_RUN;
        end
      rfs_pkg::RFS_RUN:
        if (trip) begin
          state_next = rfs_pkg::RFS_DISCHARGE;
        end
      // a pin held high never drops to 1.1V, so the block stays latched
      rfs_pkg::RFS_DISCHARGE:
        if (lvl.en_below_lo) begin
          state_next = rfs_pkg::RFS_RECHARGE;
        end
      rfs_pkg::RFS_RECHARGE:
        if (lvl.en_above_hi && !hold_hot_reg) begin
          state_next = rfs_pkg::RFS_SOFT_START;
        end
      default:
        state_next = rfs_pkg::RFS_OFF;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  wire latched   = (state_reg == rfs_pkg::RFS_DISCHARGE) ||
                   (state_reg == rfs_pkg::RFS_RECHARGE);
  wire latched_n = (state_next == rfs_pkg::RFS_DISCHARGE) ||
                   (state_next == rfs_pkg::RFS_RECHARGE);
  wire dis_next  = latched_n && (dis_reg ? !lvl.fb_below_lo :
                   (lvl.fb_above_hi || (!latched && !lvl.fb_below_lo)));
  wire hot_next  = latched_n && (ot_trip || (hold_hot_reg && !cmp.cool));
  wire pg_next   = (state_next == rfs_pkg::RFS_RUN) && lvl.ss_at_1v0 &&
                   cmp.pg_window;
  wire le_next   = (state_next == rfs_pkg::RFS_RUN);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg    <= rfs_pkg::RFS_OFF;
      uv_cnt_reg   <= `RFS_CNT_RESET;
      ov_cnt_reg   <= `RFS_CNT_RESET;
      il_cnt_reg   <= `RFS_CNT_RESET;
      latch_en_reg <= 1'b0;
      dis_reg      <= 1'b0;
      hold_hot_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      uv_cnt_reg   <= latched_n ? `RFS_CNT_RESET : uv_cnt_next;
      ov_cnt_reg   <= latched_n ? `RFS_CNT_RESET : ov_cnt_next;
      il_cnt_reg   <= latched_n ? `RFS_CNT_RESET : il_cnt_next;
      latch_en_reg <= le_next;
      dis_reg      <= dis_next;
      hold_hot_reg <= hot_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_latch     <= 1'b0;
      converter_en    <= 1'b0;
      ss_discharge    <= 1'b1;
      en_sink         <= 1'b0;
      en_pullup       <= 1'b1;
      lowside_force   <= 1'b0;
      power_good_out  <= 1'b0;
      power_good_oe_n <= 1'b0;
    end else begin
      fault_latch     <= latched_n;
      converter_en    <= (state_next == rfs_pkg::RFS_SOFT_START) ||
                         (state_next == rfs_pkg::RFS_RUN);
      ss_discharge    <= !((state_next == rfs_pkg::RFS_SOFT_START) ||
                           (state_next == rfs_pkg::RFS_RUN));
      en_sink         <= state_next == rfs_pkg::RFS_DISCHARGE;
      en_pullup       <= state_next != rfs_pkg::RFS_DISCHARGE;
      lowside_force   <= dis_next;
      power_good_out  <= 1'b0;
      power_good_oe_n <= pg_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_uv_sixteen;
    @(posedge sys_clk) disable iff (rst)
      (uv_armed && cmp.uv && !latched && uv_cnt_reg == 5'h0f) |=> fault_latch;
  endproperty
  a_uv_sixteen: assert property (p_uv_sixteen) else $error("uv trip missed");

  property p_uv_gated;
    @(posedge sys_clk) disable iff (rst)
      (!lvl.ss_at_1v0) |=> (uv_cnt_reg == 5'h00);
  endproperty
  a_uv_gated: assert property (p_uv_gated) else $error("uv counted early");

  property p_ov_two;
    @(posedge sys_clk) disable iff (rst)
      (active && cmp.ov) ##1 (active && cmp.ov) |=> fault_latch;
  endproperty
  a_ov_two: assert property (p_ov_two) else $error("ov trip missed");

  property p_ov_one;
    @(posedge sys_clk) disable iff (rst)
      (state_reg == rfs_pkg::RFS_RUN && !cmp.ov && !cmp.uv && !cmp.ilim && !cmp.hot &&
       !cmp.sw_high) ##1 (cmp.ov && !cmp.uv && !cmp.ilim && !cmp.hot && !cmp.sw_high &&
       uv_cnt_reg == 5'h00 && il_cnt_reg == 5'h00) |=> !fault_latch;
  endproperty
  a_ov_one: assert property (p_ov_one) else $error("ov tripped on one");

  property p_hs_short;
    @(posedge sys_clk) disable iff (rst)
      (active && cmp.sw_high && cmp.lowside_on) |=> (fault_latch && en_sink);
  endproperty
  a_hs_short: assert property (p_hs_short) else $error("short not latched");

  property p_sink_to_low;
    @(posedge sys_clk) disable iff (rst)
      (state_reg == rfs_pkg::RFS_DISCHARGE && lvl.en_below_lo) |=> (en_pullup && !en_sink);
  endproperty
  a_sink_to_low: assert property (p_sink_to_low) else $error("pull-up not restored");

  property p_restart;
    @(posedge sys_clk) disable iff (rst)
      (state_reg == rfs_pkg::RFS_RECHARGE && lvl.en_above_hi && !hold_hot_reg) |=>
        (converter_en && !fault_latch);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_held_high;
    @(posedge sys_clk) disable iff (rst)
      (state_reg == rfs_pkg::RFS_DISCHARGE && !lvl.en_below_lo) |=> !converter_en;
  endproperty
  a_held_high: assert property (p_held_high) else $error("restart while held");

  property p_pg_early;
    @(posedge sys_clk) disable iff (rst)
      (!lvl.ss_at_1v0 || !cmp.pg_window) |=> !power_good_oe_n;
  endproperty
  a_pg_early: assert property (p_pg_early) else $error("power good early");

  property p_lowside;
    @(posedge sys_clk) disable iff (rst)
      (lowside_force && !lvl.fb_below_lo && latched_n) |=> lowside_force;
  endproperty
  a_lowside: assert property (p_lowside) else $error("discharge stopped early");

  property p_ilim;
    @(posedge sys_clk) disable iff (rst)
      (active && cmp.ilim && il_cnt_reg == 5'h0f) |=> fault_latch;
  endproperty
  a_ilim: assert property (p_ilim) else $error("ilim trip missed");

  property p_hot_hold;
    @(posedge sys_clk) disable iff (rst)
      (hold_hot_reg && !cmp.cool) |=> !converter_en;
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("restart while hot");

  property p_pg_latch_en;
    @(posedge sys_clk) disable iff (rst)
      power_good_oe_n |-> latch_en_reg;
  endproperty
  a_pg_latch_en: assert property (p_pg_latch_en) else $error("power good before enable");

  property p_uv_clear;
    @(posedge sys_clk) disable iff (rst)
      (!cmp.uv) |=> (uv_cnt_reg == 5'h00);
  endproperty
  a_uv_clear: assert property (p_uv_clear) else $error("uv count kept");

  property p_ov_clear;
    @(posedge sys_clk) disable iff (rst)
      (!cmp.ov) |=> (ov_cnt_reg == 5'h00);
  endproperty
  a_ov_clear: assert property (p_ov_clear) else $error("ov count kept");

  property p_il_clear;
    @(posedge sys_clk) disable iff (rst)
      (!cmp.ilim) |=> (il_cnt_reg == 5'h00);
  endproperty
  a_il_clear: assert property (p_il_clear) else $error("ilim count kept");

  property p_sink_hold;
    @(posedge sys_clk) disable iff (rst)
      (state_reg == rfs_pkg::RFS_DISCHARGE && !lvl.en_below_lo) |=>
        (en_sink && !en_pullup && fault_latch);
  endproperty
  a_sink_hold: assert property (p_sink_hold) else $error("sink released early");

  property p_wait_charge;
    @(posedge sys_clk) disable iff (rst)
      (state_reg == rfs_pkg::RFS_RECHARGE && !lvl.en_above_hi) |=>
        (!converter_en && fault_latch);
  endproperty
  a_wait_charge: assert property (p_wait_charge) else $error("restart before charge");

  property p_rst_state;
    @(posedge sys_clk)
      rst |=> (ss_discharge && !fault_latch && !converter_en && !lowside_force);
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset state wrong");

  property p_ov_soft;
    @(posedge sys_clk) disable iff (rst)
      (state_reg == rfs_pkg::RFS_SOFT_START && cmp.ov && ov_cnt_reg == 5'h01) |=> fault_latch;
  endproperty
  a_ov_soft: assert property (p_ov_soft) else $error("ov missed in soft-start");

  property p_short_soft;
    @(posedge sys_clk) disable iff (rst)
      (state_reg == rfs_pkg::RFS_SOFT_START && cmp.sw_high && cmp.lowside_on) |=> fault_latch;
  endproperty
  a_short_soft: assert property (p_short_soft) else $error("short missed in soft-start");

  property p_lowside_enter;
    @(posedge sys_clk) disable iff (rst)
      (!latched && latched_n && lvl.fb_below_lo) |=> !lowside_force;
  endproperty
  a_lowside_enter: assert property (p_lowside_enter) else $error("low-side on when low");

  property p_lowside_rest;
    @(posedge sys_clk) disable iff (rst)
      (latched && !lowside_force && !lvl.fb_above_hi) |=> !lowside_force;
  endproperty
  a_lowside_rest: assert property (p_lowside_rest) else $error("low-side on again");

  property p_lowside_stop;
    @(posedge sys_clk) disable iff (rst)
      (latched && lvl.fb_below_lo && !lvl.fb_above_hi) |=> !lowside_force;
  endproperty
  a_lowside_stop: assert property (p_lowside_stop) else $error("low-side not off");

  property p_lowside_idle;
    @(posedge sys_clk) disable iff (rst)
      (!fault_latch) |-> !lowside_force;
  endproperty
  a_lowside_idle: assert property (p_lowside_idle) else $error("low-side forced unlatched");

  property p_hot_latch;
    @(posedge sys_clk) disable iff (rst)
      (active && cmp.hot) |=> (fault_latch && hold_hot_reg);
  endproperty
  a_hot_latch: assert property (p_hot_latch) else $error("hot trip missed");

  property p_pg_latched;
    @(posedge sys_clk) disable iff (rst)
      fault_latch |-> !power_good_oe_n;
  endproperty
  a_pg_latched: assert property (p_pg_latched) else $error("power good while latched");

  property p_off_quiet;
    @(posedge sys_clk) disable iff (rst)
      (state_reg == rfs_pkg::RFS_OFF && !lvl.en_above_hi) |=> !converter_en;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("start with pin low");
endmodule // rfs_supervisor
